//--- verilog/pocket_select_decoder.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Rising acknowledge edge confirms displayed message
// - Error and warning status follow display
// - Emission status true while emission enabled
// - Drive rotates pocket toward selected target
// - Single pocket is disc; parameter decides
// - Rotation output only for disc crucible
// - Drive only on six group transistors
// - Three coding modes chosen by setting
// - Decoder disabled gives zero output
// - Zero leaves selection to serial link
// - Mode 0: lowest high input wins
// - Mode 1 binary plus one; mode 2 binary
// - Source signal picks serial or decoder
// - Twelve select inputs feed decoder inputs
// - Separated data uses own source, six inputs
// - Linked data follows pocket selection
// - Position feedback coded per setting, invertible
module pocket_select_decoder
  import pocket_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [SEL_N-1:0] crucible_select_in,
  input  wire logic [REC_N-1:0] recipe_select_in,
  input  wire logic             error_ack_in,
  input  wire logic             error_shown_in,
  input  wire logic             warning_shown_in,
  input  wire logic             emission_enabled_in,
  output logic                  error_confirm,
  output logic                  error_status,
  output logic                  warning_status,
  output logic                  emission_status,
  output logic      [NUM_W-1:0] pocket_target,
  output logic                  pocket_from_io,
  output logic      [NUM_W-1:0] recipe_target,
  output logic                  recipe_from_io,
  output logic                  crucible_rotate,
  output logic      [DRV_N-1:0] group_transistor,
  output logic      [POS_N-1:0] crucible_position_bit
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    pins_t            s1;
    pins_t            s2;
    logic             ack_prev;
    ctrl_t            ctrl;
    logic [31:0]      rdata;
    logic             ready;
    logic             slverr;
    logic             confirm;
    logic             err;
    logic             warn;
    logic             emis;
    logic [NUM_W-1:0] target;
    logic             p_io;
    logic [NUM_W-1:0] recipe;
    logic             r_io;
    logic [NUM_W-1:0] cur;
    logic             rotate;
    logic [DRV_N-1:0] drive;
    logic [POS_N-1:0] pos;
  } state_t;

  state_t r;
  state_t next_r;

  logic [NUM_W-1:0] dec_pocket;
  logic [NUM_W-1:0] dec_recipe;
  logic [SEL_N-1:0] rec_wide;
  logic             moving;
  logic [NUM_W-1:0] cur_m1;
  logic [DRV_N-1:0] drive_next;

  // ----------------------------------------
  // Decoders
  // ----------------------------------------
  select_decoder u_pocket_dec (
    .in_bits (r.s2.sel),
    .enable  (r.ctrl.dec_enable),
    .mode    (r.ctrl.coding),
    .number  (dec_pocket)
  );

  // Six recipe inputs sit in the low bits; the rest read as low
  assign rec_wide = {{(SEL_N - REC_N){1'b0}}, r.s2.rec};

  select_decoder u_recipe_dec (
    .in_bits (rec_wide),
    .enable  (r.ctrl.dec_enable),
    .mode    (r.ctrl.coding),
    .number  (dec_recipe)
  );

  assign moving = r.ctrl.drive_assign[0] && r.target != NUM_ZERO && r.cur != r.target;
  assign cur_m1 = r.cur - NUM_ONE;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_r = r;
    // Two flops before any logic looks at a pin
    next_r.s1 = {crucible_select_in, recipe_select_in, error_ack_in,
                 error_shown_in, warning_shown_in, emission_enabled_in};
    next_r.s2 = r.s1;
    next_r.ack_prev = r.s2.ack;
    next_r.confirm = r.s2.ack && !r.ack_prev;
    next_r.err = r.s2.err;
    next_r.warn = r.s2.warn;
    next_r.emis = r.s2.emis;

    // APB: zero wait, data prepared in the setup cycle
    next_r.ready = 1'b1;
    if (psel && !penable) begin
      next_r.slverr = !(paddr == CTRL_ADDR || paddr == STATUS_ADDR);
      next_r.rdata = WORD_ZERO;
      if (paddr == CTRL_ADDR) begin
        next_r.rdata[CTRL_W-1:0] = r.ctrl;
      end else if (paddr == STATUS_ADDR) begin
        next_r.rdata[24:0] = {r.recipe, r.cur, r.target, r.p_io, r.emis, r.warn, r.err};
      end
    end
    if (psel && penable && pwrite && paddr == CTRL_ADDR) begin
      next_r.ctrl = ctrl_t'(pwdata[CTRL_W-1:0]);
    end

    // Zero from the decoder hands selection back to the serial link
    next_r.target = r.ctrl.pocket_src ? dec_pocket : NUM_ZERO;
    next_r.p_io = r.ctrl.pocket_src && dec_pocket != NUM_ZERO;
    if (r.ctrl.data_separate) begin
      next_r.recipe = r.ctrl.data_src ? dec_recipe : NUM_ZERO;
      next_r.r_io = r.ctrl.data_src && dec_recipe != NUM_ZERO;
    end else begin
      next_r.recipe = next_r.target;
      next_r.r_io = next_r.p_io;
    end

    // One pocket step per clock; a real drive would be slower
    if (moving) begin
      next_r.cur = (r.cur < r.target) ? r.cur + NUM_ONE : cur_m1;
    end

    // Disc crucible only: parameter alone decides rotation
    next_r.rotate = r.ctrl.single_pocket && r.ctrl.rotate_param;
    next_r.drive = drive_next;

    // Position feedback
    next_r.pos = '0;
    case (r.ctrl.coding)
      MODE_ONEHOT: begin
        if (r.cur != NUM_ZERO && r.cur <= NUM_W'(POS_N)) begin
          next_r.pos[cur_m1[2:0]] = 1'b1;
        end
      end
      MODE_PLUS1: next_r.pos = cur_m1[POS_N-1:0];
      MODE_BINARY: next_r.pos = r.cur[POS_N-1:0];
      default: next_r.pos = '0;
    endcase
    if (r.ctrl.pos_invert) begin
      next_r.pos = ~next_r.pos;
    end
  end

  // Each assigned transistor carries the drive while transistor 0 is assigned; inverted form has no use
  for (genvar g = 0; g < DRV_N; g++) begin : g_drive
    assign drive_next[g] = r.ctrl.drive_assign[g] && moving;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.ctrl <= ctrl_t'(CTRL_RESET);
    end else begin
      r <= next_r;
    end
  end

  assign prdata                = r.rdata;
  assign pready                = r.ready;
  assign pslverr               = r.slverr;
  assign error_confirm         = r.confirm;
  assign error_status          = r.err;
  assign warning_status        = r.warn;
  assign emission_status       = r.emis;
  assign pocket_target         = r.target;
  assign pocket_from_io        = r.p_io;
  assign recipe_target         = r.recipe;
  assign recipe_from_io        = r.r_io;
  assign crucible_rotate       = r.rotate;
  assign group_transistor      = r.drive;
  assign crucible_position_bit = r.pos;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence ack_rise_s;
    !error_ack_in ##1 error_ack_in [*3];
  endsequence

  ack_edge_a: assert property (ack_rise_s |=> error_confirm)
    else $error("Acknowledge edge not confirmed");
  ack_level_a: assert property (error_confirm |=> !error_confirm)
    else $error("Static acknowledge level confirmed twice");
  err_follow_a: assert property (error_shown_in [*4] |-> error_status)
    else $error("Error status lags display");
  emis_follow_a: assert property (!emission_enabled_in [*4] |-> !emission_status)
    else $error("Emission status wrong");
  disable_zero_a: assert property (!r.ctrl.dec_enable |-> dec_pocket == NUM_ZERO)
    else $error("Disabled decoder output not zero");
  mode0_low_a: assert property (r.ctrl.dec_enable && r.ctrl.coding == MODE_ONEHOT
                                && r.s2.sel[0] |-> dec_pocket == NUM_ONE)
    else $error("Lowest input does not win");
  mode1_plus_a: assert property (r.ctrl.dec_enable && r.ctrl.coding == MODE_PLUS1
                                 && r.s2.sel[SEL_N-1:PLUS1_IN_N] == '0
                                 |-> dec_pocket == {1'b0, r.s2.sel[PLUS1_IN_N-1:0]} + NUM_ONE)
    else $error("Mode one value wrong");
  src_serial_a: assert property (!r.ctrl.pocket_src |=> pocket_target == NUM_ZERO && !pocket_from_io)
    else $error("Serial source yet decoder drives");
  link_follow_a: assert property (!r.ctrl.data_separate |=> recipe_target == pocket_target)
    else $error("Linked data not following pocket");
  rotate_disc_a: assert property (!r.ctrl.single_pocket |=> !crucible_rotate)
    else $error("Rotation without disc crucible");
  drive_step_a: assert property (moving && r.cur < r.target |=> r.cur == $past(r.cur) + NUM_ONE)
    else $error("Drive does not step toward target");

  // ----------------------------------------
  // Status and acknowledge checks
  // ----------------------------------------

  sequence err_clear_s;
    !error_shown_in [*4];
  endsequence

  err_clear_a: assert property (err_clear_s |-> !error_status)
    else $error("Error status stays after display clears");

  sequence warn_set_s;
    warning_shown_in [*4];
  endsequence

  warn_set_a: assert property (warn_set_s |-> warning_status)
    else $error("Warning status lags display");

  sequence warn_clear_s;
    !warning_shown_in [*4];
  endsequence

  warn_clear_a: assert property (warn_clear_s |-> !warning_status)
    else $error("Warning status stays after display clears");

  sequence emis_set_s;
    emission_enabled_in [*4];
  endsequence

  emis_set_a: assert property (emis_set_s |-> emission_status)
    else $error("Emission status lags enable");

  ack_quiet_a: assert property (!error_ack_in [*4] |-> !error_confirm)
    else $error("Confirm without acknowledge edge");

  ack_static_a: assert property (error_ack_in [*6] |-> !error_confirm)
    else $error("Static acknowledge level confirmed");

  // ----------------------------------------
  // Decoder checks
  // ----------------------------------------

  mode0_top_a: assert property (r.ctrl.dec_enable && r.ctrl.coding == MODE_ONEHOT
                                && r.s2.sel == {1'b1, {(SEL_N - 1){1'b0}}}
                                |-> dec_pocket == NUM_W'(SEL_N))
    else $error("Top input alone does not select last pocket");

  mode0_none_a: assert property (r.ctrl.dec_enable && r.ctrl.coding == MODE_ONEHOT
                                 && r.s2.sel == '0
                                 |-> dec_pocket == NUM_ZERO)
    else $error("No input high yet pocket selected");

  mode1_over_a: assert property (r.ctrl.dec_enable && r.ctrl.coding == MODE_PLUS1
                                 && r.s2.sel[SEL_N-1:PLUS1_IN_N] != '0
                                 |-> dec_pocket == NUM_ZERO)
    else $error("Mode one overflow not zero");

  mode2_bin_a: assert property (r.ctrl.dec_enable && r.ctrl.coding == MODE_BINARY
                                && r.s2.sel[SEL_N-1:BIN_IN_N] == '0
                                && r.s2.sel[BIN_IN_N-1:0] <= BIN_MAX
                                |-> dec_pocket == r.s2.sel[BIN_IN_N-1:0])
    else $error("Mode two value wrong");

  mode2_over_a: assert property (r.ctrl.dec_enable && r.ctrl.coding == MODE_BINARY
                                 && r.s2.sel[BIN_IN_N-1:0] > BIN_MAX
                                 |-> dec_pocket == NUM_ZERO)
    else $error("Mode two overflow not zero");

  mode_spare_a: assert property (r.ctrl.coding != MODE_ONEHOT && r.ctrl.coding != MODE_PLUS1
                                 && r.ctrl.coding != MODE_BINARY
                                 |-> dec_pocket == NUM_ZERO)
    else $error("Unused coding mode not zero");

  rec_disable_a: assert property (!r.ctrl.dec_enable |-> dec_recipe == NUM_ZERO)
    else $error("Disabled recipe decoder not zero");

  // ----------------------------------------
  // Selection, drive and feedback checks
  // ----------------------------------------

  src_io_a: assert property (r.ctrl.pocket_src |=> pocket_target == $past(dec_pocket))
    else $error("Decoder source not passed to target");

  io_flag_a: assert property (pocket_from_io |-> pocket_target != NUM_ZERO)
    else $error("Decoder flagged with zero pocket");

  sep_serial_a: assert property (r.ctrl.data_separate && !r.ctrl.data_src
                                 |=> recipe_target == NUM_ZERO && !recipe_from_io)
    else $error("Separated serial recipe driven by decoder");

  sep_io_a: assert property (r.ctrl.data_separate && r.ctrl.data_src |=> recipe_target == $past(dec_recipe))
    else $error("Separated recipe not from its decoder");

  drive_down_a: assert property (moving && r.cur > r.target |=> r.cur == $past(r.cur) - NUM_ONE)
    else $error("Drive does not step down toward target");

  drive_hold_a: assert property (!moving |=> r.cur == $past(r.cur))
    else $error("Pocket moved without drive");

  drive_only_a: assert property (r.ctrl.drive_assign != '1
                                 |=> (group_transistor & ~$past(r.ctrl.drive_assign)) == '0)
    else $error("Unassigned transistor carries drive");

  rotate_on_a: assert property (r.ctrl.single_pocket && r.ctrl.rotate_param |=> crucible_rotate)
    else $error("Disc crucible not rotating");

  // Only a settled pocket is compared; feedback trails the pocket by a cycle
  pos_bin_a: assert property (r.ctrl.coding == MODE_BINARY && !r.ctrl.pos_invert
                              && $stable(r.cur) && $stable(r.ctrl)
                              |-> crucible_position_bit == r.cur[POS_N-1:0])
    else $error("Binary position feedback wrong");
endmodule
`default_nettype wire

//--- verilog/pocket_pkg.sv
`default_nettype none
package pocket_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int SEL_N = 12;
  localparam int REC_N = 6;
  localparam int POS_N = 6;
  localparam int DRV_N = 6;
  localparam int NUM_W = 7;

  // ----------------------------------------
  // Decoder figures
  // ----------------------------------------
  localparam logic [1:0]       MODE_ONEHOT  = 2'h0;
  localparam logic [1:0]       MODE_PLUS1   = 2'h1;
  localparam logic [1:0]       MODE_BINARY  = 2'h2;
  localparam logic [NUM_W-1:0] NUM_ZERO     = 7'h00;
  localparam logic [NUM_W-1:0] NUM_ONE      = 7'h01;
  localparam logic [NUM_W-1:0] BIN_MAX      = 7'h40;
  localparam int               BIN_IN_N     = 7;
  localparam int               PLUS1_IN_N   = 6;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] CTRL_ADDR   = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;
  localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;

  typedef struct packed {
    logic [DRV_N-1:0] drive_assign;
    logic             single_pocket;
    logic             pos_invert;
    logic             rotate_param;
    logic             data_separate;
    logic             data_src;
    logic             pocket_src;
    logic [1:0]       coding;
    logic             dec_enable;
  } ctrl_t;

  localparam int            CTRL_W     = $bits(ctrl_t);
  localparam logic [14:0]   CTRL_RESET = 15'h0000;

  // Pins from the process equipment
  typedef struct packed {
    logic [SEL_N-1:0] sel;
    logic [REC_N-1:0] rec;
    logic             ack;
    logic             err;
    logic             warn;
    logic             emis;
  } pins_t;

  localparam int PINS_W = $bits(pins_t);
endpackage
`default_nettype wire

//--- verilog/select_decoder.sv
`timescale 1ns/10ps
`default_nettype none
module select_decoder
  import pocket_pkg::*;
(
  input  wire logic [SEL_N-1:0] in_bits,
  input  wire logic             enable,
  input  wire logic [1:0]       mode,
  output logic      [NUM_W-1:0] number
);
  logic [NUM_W-1:0] lowest;

  always_comb begin
    lowest = NUM_ZERO;
    for (int i = SEL_N - 1; i >= 0; i--) begin
      if (in_bits[i]) begin
        lowest = NUM_W'(i + 1);
      end
    end
  end

  always_comb begin
    number = NUM_ZERO;
    if (enable) begin
      case (mode)
        MODE_ONEHOT: number = lowest;
        MODE_PLUS1: begin
          if (in_bits[SEL_N-1:PLUS1_IN_N] == '0) begin
            number = NUM_W'({1'b0, in_bits[PLUS1_IN_N-1:0]}) + NUM_ONE;
          end
        end
        MODE_BINARY: begin
          if (in_bits[SEL_N-1:BIN_IN_N] == '0 && in_bits[BIN_IN_N-1:0] <= BIN_MAX) begin
            number = in_bits[BIN_IN_N-1:0];
          end
        end
        default: number = NUM_ZERO;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- verification/process_equipment.sv
`timescale 1ns/10ps
`default_nettype none
module process_equipment
  import pocket_pkg::*;
(
  input  wire logic  pclk,
  input  wire pins_t cmd,
  output pins_t      pins
);
  // ----------------------------------------
  // Contacts of the process equipment
  // ----------------------------------------
  // Outputs move only after a clock edge, like relay contacts
  initial begin
    pins = '0;
  end
  always @(posedge pclk) begin
    pins <= cmd;
  end
endmodule
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pocket_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic             pclk            = 1'b0;
  logic             presetn         = 1'b0;
  logic             psel            = 1'b0;
  logic             penable         = 1'b0;
  logic             pwrite          = 1'b0;
  logic [11:0]      paddr           = 12'h000;
  logic [31:0]      pwdata          = 32'h0000_0000;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  pins_t            cmd             = '0;
  pins_t            pins;
  logic             confirm;
  logic             err_st;
  logic             warn_st;
  logic             emis_st;
  logic [NUM_W-1:0] pocket_target;
  logic             pocket_io;
  logic [NUM_W-1:0] recipe_target;
  logic             recipe_io;
  logic             rotate;
  logic [DRV_N-1:0] gt;
  logic [POS_N-1:0] pos;
  logic [31:0]      q;
  logic             e;
  int               n;
  int               mismatches      = 0;
  int               samples_checked = 0;

  typedef struct packed {
    logic [14:0] ctrl;
    logic [11:0] sel;
    logic [5:0]  rec;
    logic [6:0]  p;
    logic [6:0]  r;
  } row_t;

  // Ordinary decoder cases; pocket_src always set so the decoder commands
  row_t rows [14] = '{
    '{15'h0009, 12'h000, 6'h00, 7'h00, 7'h00}, '{15'h0009, 12'h006, 6'h00, 7'h02, 7'h02},
    '{15'h0009, 12'h800, 6'h00, 7'h0c, 7'h0c}, '{15'h000b, 12'h000, 6'h00, 7'h01, 7'h01},
    '{15'h000b, 12'h03f, 6'h00, 7'h40, 7'h40}, '{15'h000b, 12'h040, 6'h00, 7'h00, 7'h00},
    '{15'h000d, 12'h040, 6'h00, 7'h40, 7'h40}, '{15'h000d, 12'h041, 6'h00, 7'h00, 7'h00},
    '{15'h000d, 12'h020, 6'h00, 7'h20, 7'h20}, '{15'h000a, 12'h005, 6'h00, 7'h00, 7'h00},
    '{15'h000f, 12'h001, 6'h00, 7'h00, 7'h00}, '{15'h003d, 12'h003, 6'h3f, 7'h03, 7'h3f},
    '{15'h003b, 12'h001, 6'h02, 7'h02, 7'h03}, '{15'h0039, 12'h004, 6'h0c, 7'h03, 7'h03}};

  always #5 pclk = ~pclk;

  process_equipment equip (.pclk(pclk), .cmd(cmd), .pins(pins));

  pocket_select_decoder uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crucible_select_in(pins.sel), .recipe_select_in(pins.rec), .error_ack_in(pins.ack),
    .error_shown_in(pins.err), .warning_shown_in(pins.warn), .emission_enabled_in(pins.emis),
    .error_confirm(confirm), .error_status(err_st), .warning_status(warn_st),
    .emission_status(emis_st), .pocket_target(pocket_target), .pocket_from_io(pocket_io),
    .recipe_target(recipe_target), .recipe_from_io(recipe_io), .crucible_rotate(rotate),
    .group_transistor(gt), .crucible_position_bit(pos));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge pclk);
  endtask

  // One APB transfer; an idle edge follows so strobes never toggle twice in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int w;
    w = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && w < 50) begin
      @(posedge pclk);
      w++;
    end
    if (w == 50) mismatches++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #200_000;
    mismatches++;
    test_done();
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    tick(12);
    check(32'({pready, pocket_target}), 32'h0000_0000);
    presetn <= 1'b1;
    tick(2);
    apb(1'b0, CTRL_ADDR, WORD_ZERO);
    check(q, 32'h0000_0000);
    apb(1'b0, 12'h008, WORD_ZERO);
    check({q[30:0], e}, 32'h0000_0001);
    foreach (rows[i]) begin
      apb(1'b1, CTRL_ADDR, 32'(rows[i].ctrl));
      cmd.sel <= rows[i].sel;
      cmd.rec <= rows[i].rec;
      tick(7);
      check(32'(pocket_target), 32'(rows[i].p));
      check(32'(recipe_target), 32'(rows[i].r));
      check(32'({pocket_io, recipe_io}), {30'h0, {2{rows[i].p != 7'h00}}});
      apb(1'b0, STATUS_ADDR, WORD_ZERO);
      check(32'(q[10:3]), 32'({rows[i].p, rows[i].p != 7'h00}));
    end
    // Acknowledge: one pulse per rising edge, none from a held level
    cmd.ack <= 1'b1;
    n = 0;
    repeat (12) begin
      @(posedge pclk);
      n += int'(confirm === 1'b1);
    end
    check(32'(n), 32'h0000_0001);
    tick(12);
    check(32'(confirm), 32'h0000_0000);
    cmd.err <= 1'b1;
    cmd.emis <= 1'b1;
    tick(7);
    check(32'({err_st, warn_st, emis_st}), 32'h0000_0005);
    cmd.err <= 1'b0;
    cmd.warn <= 1'b1;
    cmd.emis <= 1'b0;
    tick(7);
    check(32'({err_st, warn_st, emis_st}), 32'h0000_0002);
    // Disc crucible rotation needs single pocket and the parameter
    apb(1'b1, CTRL_ADDR, 32'h0000_0140);
    tick(2);
    check(32'(rotate), 32'h0000_0001);
    apb(1'b1, CTRL_ADDR, 32'h0000_0040);
    tick(2);
    check(32'(rotate), 32'h0000_0000);
    // Drive assigned to the first group 1 transistor, as the process side must do
    cmd.sel <= 12'h004;
    apb(1'b1, CTRL_ADDR, 32'h0000_0209);
    n = 0;
    repeat (20) begin
      @(posedge pclk);
      n += int'(gt[0] === 1'b1);
    end
    check(32'(n != 0), 32'h0000_0001);
    check(32'({gt, pos}), 32'h0000_0004);
    apb(1'b1, CTRL_ADDR, 32'h0000_0289);
    tick(3);
    check(32'(pos), 32'h0000_003b);
    cmd.sel <= 12'h005;
    apb(1'b1, CTRL_ADDR, 32'h0000_020d);
    tick(16);
    check(32'(pos), 32'h0000_0005);
    test_done();
  end
endmodule
`default_nettype wire
